/* bench/tb.sv */
`timescale 1ns/10ps
module tb;
  import wake_pkg::*;
  logic i_sys_clk, i_rst_n, i_avs_read, i_avs_write, i_frame_valid, i_pattern_hit;
  logic i_power_saving, i_resume_done, i_resume_clears_flags, o_avs_waitrequest, o_wake_event;
  logic o_global_unicast_wake_on, o_pattern_wake_on, o_own_address_wake_on, o_own_address_hit_flag;
  logic [11:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_match_data, q;
  logic [31:0] mem [40];
  logic [3:0] i_avs_byteenable;
  logic [47:0] i_frame_dest_addr, i_own_mac_addr;
  logic [5:0] i_match_index, o_filter_rd_ptr, o_filter_wr_ptr, rp, wp;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  wakeup_filter_access i_dut (.*);
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // A hung handshake ends here rather than stalling the run.
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  function automatic logic [5:0] nx(input logic [5:0] p);
    return (p == 6'h27) ? 6'h00 : p + 6'h01;
  endfunction : nx
  function automatic logic ew(input logic [2:0] c, input logic me, h, p, g);
    return p & ((c[0] & h) | (c[0] & c[2] & !g) | (c[1] & me));
  endfunction : ew
  // The request is held until the rising edge that sees waitrequest low; the timeout ends a hang.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    do begin
      @(posedge i_sys_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
  endtask : bus
  task automatic wwin(input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, OFFS_FILTER_WINDOW, d, be);
    for (int i = 0; i < 4; i++)
      if (be[i])
        mem[wp][8*i +: 8] = d[8*i +: 8];
    wp = nx(wp);
  endtask : wwin
  task automatic rwin;
    bus(1'b0, OFFS_FILTER_WINDOW, 32'h0, 4'hf);
    check("window", q, mem[rp]);
    rp = nx(rp);
  endtask : rwin
  task automatic idle;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(negedge i_sys_clk);
    check("rd_ptr", 32'(o_filter_rd_ptr), 32'(rp));
    check("wr_ptr", 32'(o_filter_wr_ptr), 32'(wp));
    @(posedge i_sys_clk);
  endtask : idle
  initial begin
    logic [47:0] d;
    logic [31:0] v;
    logic [31:0] pv;
    logic [2:0] c;
    logic me, h, p, ef;
    int k;
    void'($urandom(32'h1416));
    {i_rst_n, i_avs_read, i_avs_write, i_frame_valid, i_pattern_hit} = 5'h00;
    {i_power_saving, i_resume_done, i_resume_clears_flags} = 3'h0;
    i_avs_address = 12'h000;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hf;
    i_frame_dest_addr = 48'h0;
    i_own_mac_addr = 48'h02a4_5c31_9e70;
    i_match_index = 6'h00;
    rp = 6'h00;
    wp = 6'h00;
    ef = 1'b0;
    foreach (mem[i])
      mem[i] = 32'h0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    idle();
    rwin();
    for (int i = 0; i < 43; i++)
      wwin($urandom, (i == 7) ? 4'h5 : 4'hf);
    for (int i = 0; i < 41; i++)
      rwin();
    idle();
    for (int i = 0; i < 8; i++) begin
      k = (i == 0) ? 39 : (i == 1) ? 40 : $urandom_range(47);
      i_match_index <= 6'(k);
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check("match", o_match_data, (k > 39) ? 32'h0 : mem[k]);
      @(posedge i_sys_clk);
    end
    wwin($urandom, 4'hf);
    rwin();
    idle();
    bus(1'b1, OFFS_WAKE_CTRL, 32'h8000_020c, 4'hf);
    rp = 6'h00;
    wp = 6'h00;
    idle();
    bus(1'b0, OFFS_WAKE_CTRL, 32'h0, 4'hf);
    check("ctrl", q, 32'h0000_020c);
    rwin();
    bus(1'b0, 12'h130, 32'h0, 4'hf);
    check("unmapped", q, 32'h0);
    idle();
    pv = 32'h0000_020c;
    for (int ci = 0; ci < 8; ci++) begin
      c = 3'(ci);
      v = (32'(c[2]) << 9) | (32'(c[1]) << 3) | (32'(c[0]) << 2);
      bus(1'b0, OFFS_WAKE_CTRL, 32'h0, 4'hf);
      check("ctrl", q, pv | (32'(ef) << 7));
      bus(1'b1, OFFS_WAKE_CTRL, v | 32'h80, 4'hf);
      bus(1'b0, OFFS_WAKE_CTRL, 32'h0, 4'hf);
      check("ctrl", q, v);
      ef = 1'b0;
      pv = v;
      idle();
      for (int j = 0; j < 8; j++) begin
        me = 1'($urandom_range(1));
        h = 1'($urandom_range(1));
        p = (j < 6) ? 1'b1 : 1'b0;
        d = me ? i_own_mac_addr : {$urandom, $urandom};
        i_frame_valid <= 1'b1;
        i_frame_dest_addr <= d;
        i_pattern_hit <= h;
        i_power_saving <= p;
        @(posedge i_sys_clk);
        i_frame_valid <= 1'b0;
        ef = ef | me;
        @(negedge i_sys_clk);
        check("wake", 32'(o_wake_event), 32'(ew(c, me, h, p, d[0])));
        check("flag", 32'(o_own_address_hit_flag), 32'(ef));
        @(posedge i_sys_clk);
      end
      i_resume_clears_flags <= c[0];
      i_resume_done <= 1'b1;
      @(posedge i_sys_clk);
      i_resume_done <= 1'b0;
      ef = ef & !c[0];
      @(negedge i_sys_clk);
      check("resume", 32'(o_own_address_hit_flag), 32'(ef));
      @(posedge i_sys_clk);
    end
    bus(1'b1, OFFS_WAKE_CTRL, 32'h8000_0000, 4'hf);
    rp = 6'h00;
    wp = 6'h00;
    for (int i = 0; i < 40; i++)
      rwin();
    idle();
    tally_and_finish();
  end
endmodule : tb

/* bench/wakeup_filter_access_assertions.sv */
`timescale 1ns/10ps
module wakeup_filter_access_assertions #(
  parameter int unsigned FILTER_WORDS = 40
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_frame_valid,
  input wire logic [47:0] i_frame_dest_addr,
  input wire logic [47:0] i_own_mac_addr,
  input wire logic i_power_saving,
  input wire logic i_resume_done,
  input wire logic i_resume_clears_flags,
  input wire logic o_wake_event,
  input wire logic o_global_unicast_wake_on,
  input wire logic o_pattern_wake_on,
  input wire logic o_own_address_wake_on,
  input wire logic o_own_address_hit_flag,
  input wire logic [5:0] o_filter_rd_ptr,
  input wire logic [5:0] o_filter_wr_ptr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic own;
  logic acc;
  assign own = i_frame_valid && i_frame_dest_addr == i_own_mac_addr;
  assign acc = !o_avs_waitrequest && i_avs_address == 12'h128;
  property p_rd_step;
    i_avs_read && acc |=> o_filter_rd_ptr == (($past(o_filter_rd_ptr) ==
      6'(FILTER_WORDS - 1)) ? 6'h00 : $past(o_filter_rd_ptr) + 6'h01);
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read pointer step wrong");
  property p_wr_step;
    i_avs_write && acc |=> o_filter_wr_ptr == (($past(o_filter_wr_ptr) ==
      6'(FILTER_WORDS - 1)) ? 6'h00 : $past(o_filter_wr_ptr) + 6'h01);
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("write pointer step wrong");
  property p_ptr_clear;
    i_avs_write && !o_avs_waitrequest && i_avs_address == 12'h12c && i_avs_writedata[31] &&
      i_avs_byteenable[3]
      |=> o_filter_rd_ptr == 6'h00 && o_filter_wr_ptr == 6'h00;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointers not cleared");
  property p_wr_hold;
    !i_avs_write || o_avs_waitrequest |=> $stable(o_filter_wr_ptr);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write pointer moved");
  property p_hit_set;
    own |=> o_own_address_hit_flag;
  endproperty
  a_hit_set: assert property (p_hit_set) else $error("hit flag not set");
  property p_unicast;
    i_frame_valid && i_power_saving && o_global_unicast_wake_on && o_pattern_wake_on &&
      !i_frame_dest_addr[0] |=> o_wake_event;
  endproperty
  a_unicast: assert property (p_unicast) else $error("unicast wake missing");
  property p_no_pattern;
    i_frame_valid && !o_pattern_wake_on && !(o_own_address_wake_on && own) |=> !o_wake_event;
  endproperty
  a_no_pattern: assert property (p_no_pattern) else $error("wake without enable");
  property p_resume;
    i_resume_done && i_resume_clears_flags && !own |=> !o_own_address_hit_flag;
  endproperty
  a_resume: assert property (p_resume) else $error("resume left flag set");
  c_wrap: cover property (o_filter_wr_ptr == 6'h27 && i_avs_write && acc);
  c_wake: cover property (o_wake_event);
  c_resume: cover property (i_resume_done && i_resume_clears_flags && o_own_address_hit_flag);
endmodule : wakeup_filter_access_assertions
bind wakeup_filter_access wakeup_filter_access_assertions #(.FILTER_WORDS(FILTER_WORDS)) i_chk (.*);

/* design/sticky_flag.sv */
`timescale 1ns/10ps
module sticky_flag (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  import wake_pkg::*;

  logic flag_reg;

  // A set in the clearing cycle wins, so no received event is lost.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= RESET_CTRL_BIT;
    end else if (i_set) begin
      flag_reg <= 1'b1;
    end else if (i_clear) begin
      flag_reg <= 1'b0;
    end
  end

  assign o_flag = flag_reg;

endmodule : sticky_flag

/* design/wake_pkg.sv */
package wake_pkg;

  // Bus geometry.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned LANE_W = 8;

  // Filter store geometry: 40 dwords make up 8 filters.
  localparam int unsigned FILTER_WORDS = 40;
  localparam int unsigned FILTER_COUNT = 8;
  localparam int unsigned PTR_W = 6;

  // Station addresses.
  localparam int unsigned MAC_W = 48;
  localparam int unsigned DA_GROUP_BIT = 0;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFFS_FILTER_WINDOW = 12'h128;
  localparam logic [ADDR_W-1:0] OFFS_WAKE_CTRL = 12'h12c;

  // Field positions in the wake control and status register.
  localparam int unsigned BIT_POINTER_CLEAR = 31;
  localparam int unsigned BIT_GLOBAL_UNICAST = 9;
  localparam int unsigned BIT_OWN_HIT_FLAG = 7;
  localparam int unsigned BIT_OWN_ADDR_WAKE = 3;
  localparam int unsigned BIT_PATTERN_WAKE = 2;

  // Reset values.
  localparam logic [DATA_W-1:0] RESET_FILTER_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;
  localparam logic RESET_CTRL_BIT = 1'b0;
  localparam logic [PTR_W-1:0] PTR_FIRST = 6'h00;

  // Bus answer sequencer, Gray coded along idle to answer.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ANSWER = 2'b01
  } bus_state_e;

endpackage : wake_pkg

/* design/wakeup_filter_access.sv */
// Behaviour
// - After reset the first window write lands in dword 0, then each next dword.
// - Store holds 40 dwords as 8 filters; pointer wraps after the 40th access.
// - Successive window reads return stored dwords in order, one step per read.
// - Filter window is 32-bit read/write at 128h, reset value zero.
// - Pointers stay where an incomplete run left them; no automatic realignment.
// - Writing one to control bit 31 resets both pointers; the bit self-clears.
// - Global unicast enable bit 9 wakes on a frame with address bit 0 zero.
// - Global unicast wake also needs the pattern wake enable bit set.
// - Bit 7 sets on a valid frame to the own address; a software write of one clears it.
// - With resume clearing enabled, a completed resume clears bit 7.
// - Control bit 2 enables wake on frames matching the stored patterns.
// - Control bit 3 enables wake on frames to the own physical address.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
module wakeup_filter_access #(
  parameter int unsigned FILTER_WORDS = wake_pkg::FILTER_WORDS,
  parameter int unsigned PTR_W = wake_pkg::PTR_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [wake_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [wake_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [wake_pkg::BE_W-1:0] i_avs_byteenable,
  output logic [wake_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_frame_valid,
  input wire logic [wake_pkg::MAC_W-1:0] i_frame_dest_addr,
  input wire logic [wake_pkg::MAC_W-1:0] i_own_mac_addr,
  input wire logic i_pattern_hit,
  input wire logic i_power_saving,
  input wire logic i_resume_done,
  input wire logic i_resume_clears_flags,
  input wire logic [PTR_W-1:0] i_match_index,
  output logic [wake_pkg::DATA_W-1:0] o_match_data,
  output logic o_wake_event,
  output logic o_global_unicast_wake_on,
  output logic o_pattern_wake_on,
  output logic o_own_address_wake_on,
  output logic o_own_address_hit_flag,
  output logic [PTR_W-1:0] o_filter_rd_ptr,
  output logic [PTR_W-1:0] o_filter_wr_ptr
);
  import wake_pkg::*;

  // Each control field is written only when the byte lane that carries it is enabled.
  // This lets software update bit 9 alone without a read-modify-write; bits 2 and 3 share byte lane 0 and are written together.
  localparam logic [PTR_W-1:0] LAST_INDEX = PTR_W'(FILTER_WORDS - 1);
  localparam int unsigned LANE_GLOBAL_UNICAST_WAKE_ON = BIT_GLOBAL_UNICAST / LANE_W;
  localparam int unsigned LANE_FLAG = BIT_OWN_HIT_FLAG / LANE_W;
  localparam int unsigned LANE_OWN = BIT_OWN_ADDR_WAKE / LANE_W;
  localparam int unsigned LANE_PAT = BIT_PATTERN_WAKE / LANE_W;
  localparam int unsigned LANE_CLR = BIT_POINTER_CLEAR / LANE_W;

  // Bus sequencer and decode.
  bus_state_e state_reg;
  bus_state_e state_next;
  logic request;
  logic accept;
  logic sel_window;
  logic sel_ctrl;
  logic [DATA_W-1:0] readdata_reg;
  logic [DATA_W-1:0] readdata_next;

  // Filter store and its pointers.
  logic [DATA_W-1:0] filter_store [0:FILTER_WORDS-1];
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] wr_ptr;
  logic window_read_done;
  logic window_write_done;
  logic pointer_clear;
  logic [DATA_W-1:0] wake_filter_data;
  logic [DATA_W-1:0] merged_word;

  // Control bits.
  logic global_unicast_wake_on_reg;
  logic pattern_wake_on_reg;
  logic own_address_wake_on_reg;
  logic ctrl_write;
  logic own_address_hit_flag;
  logic flag_set;
  logic flag_clear;

  // Wake decision.
  logic own_addr_match;
  logic global_unicast_frame;
  logic wake_next;
  logic wake_event_reg;
  logic [DATA_W-1:0] match_data_reg;

  // Partial window writes keep the unselected bytes of the addressed dword.
  // The pointer still advances, so a partial write consumes a whole entry.
  // Software that wants to patch one byte must therefore walk the full run.
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [BE_W-1:0] lanes
  );
    logic [DATA_W-1:0] result;
    result = old_word;
    for (int i = 0; i < BE_W; i++) begin
      if (lanes[i]) begin
        result[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return result;
  endfunction : merge_bytes

  assign request = i_avs_read | i_avs_write;
  assign sel_window = (i_avs_address == OFFS_FILTER_WINDOW);
  assign sel_ctrl = (i_avs_address == OFFS_WAKE_CTRL);

  // Every access, mapped or not, waits exactly one cycle and then completes.
  assign o_avs_waitrequest = request & (state_reg != ST_ANSWER);
  assign accept = request & (state_reg == ST_ANSWER);

  // One wait cycle gives the read data a register stage before the answer.
  // The cost is a fixed extra cycle per access, which this slow path can afford.
  // Unmapped addresses take the same path so the bus never hangs.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (request) begin
          state_next = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pointers move only on the completing edge of an access.
  // read step
  assign window_read_done = accept & i_avs_read & sel_window;
  assign window_write_done = accept & i_avs_write & sel_window;
  assign pointer_clear = accept & i_avs_write & sel_ctrl & i_avs_byteenable[LANE_CLR]
                         & i_avs_writedata[BIT_POINTER_CLEAR];

  // Reads and writes walk the store independently of each other.
  // An aborted read run therefore never disturbs where the next write lands.
  // Only the pointer clear bit or a device reset brings them back to the start.
  // read pointer
  wrap_pointer #(
    .DEPTH(FILTER_WORDS),
    .PTR_W(PTR_W)
  ) u_rd_ptr (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_step(window_read_done),
    .i_clear(pointer_clear),
    .o_ptr(rd_ptr)
  );

  wrap_pointer #(
    .DEPTH(FILTER_WORDS),
    .PTR_W(PTR_W)
  ) u_wr_ptr (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_step(window_write_done),
    .i_clear(pointer_clear),
    .o_ptr(wr_ptr)
  );

  assign wake_filter_data = filter_store[rd_ptr];
  assign merged_word = merge_bytes(filter_store[wr_ptr], i_avs_writedata, i_avs_byteenable);

  // The whole store clears on reset, so a read before any write returns zeros.
  // This costs a reset on every storage bit in exchange for a known matcher view.
  // A memory macro without reset would need a separate clearing walk instead.
  // store reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < FILTER_WORDS; i++) begin
        filter_store[i] <= RESET_FILTER_WORD;
      end
    end else if (window_write_done) begin
      filter_store[wr_ptr] <= merged_word;
    end
  end

  // Read data is built in the waiting cycle and held through the answer.
  always_comb begin
    readdata_next = READ_UNMAPPED;
    if (sel_window) begin
      readdata_next = wake_filter_data;
    end else if (sel_ctrl) begin
      readdata_next[BIT_GLOBAL_UNICAST] = global_unicast_wake_on_reg;
      readdata_next[BIT_OWN_HIT_FLAG] = own_address_hit_flag;
      readdata_next[BIT_OWN_ADDR_WAKE] = own_address_wake_on_reg;
      readdata_next[BIT_PATTERN_WAKE] = pattern_wake_on_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      readdata_reg <= READ_UNMAPPED;
    end else if (request & i_avs_read & (state_reg == ST_IDLE)) begin
      readdata_reg <= readdata_next;
    end
  end

  assign o_avs_readdata = readdata_reg;

  // The pointer clear bit has no storage, so it always reads back as zero.
  assign ctrl_write = accept & i_avs_write & sel_ctrl;

  // The enables are plain read/write bits with no side effects of their own.
  // They only gate the wake decision further below and are exported as levels.
  // A write with their lane disabled leaves them untouched.
  // unicast enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      global_unicast_wake_on_reg <= RESET_CTRL_BIT;
    end else if (ctrl_write & i_avs_byteenable[LANE_GLOBAL_UNICAST_WAKE_ON]) begin
      global_unicast_wake_on_reg <= i_avs_writedata[BIT_GLOBAL_UNICAST];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pattern_wake_on_reg <= RESET_CTRL_BIT;
    end else if (ctrl_write & i_avs_byteenable[LANE_PAT]) begin
      pattern_wake_on_reg <= i_avs_writedata[BIT_PATTERN_WAKE];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      own_address_wake_on_reg <= RESET_CTRL_BIT;
    end else if (ctrl_write & i_avs_byteenable[LANE_OWN]) begin
      own_address_wake_on_reg <= i_avs_writedata[BIT_OWN_ADDR_WAKE];
    end
  end

  // The destination address is only meaningful while the frame valid pulse is high.
  // Every use below is qualified by that pulse, so stale addresses are harmless.
  // The group bit decides between unicast and multicast destinations.
  assign own_addr_match = (i_frame_dest_addr == i_own_mac_addr);
  assign global_unicast_frame = ~i_frame_dest_addr[DA_GROUP_BIT];

  assign flag_set = i_frame_valid & own_addr_match;
  assign flag_clear = (ctrl_write & i_avs_byteenable[LANE_FLAG]
                       & i_avs_writedata[BIT_OWN_HIT_FLAG])
                      | (i_resume_done & i_resume_clears_flags);

  // The hit flag records every own address frame, whatever the enables say.
  // Software clears it by writing one, or a finished resume clears it when allowed.
  // A frame arriving in the clearing cycle keeps the flag set.
  sticky_flag u_own_hit (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_set(flag_set),
    .i_clear(flag_clear),
    .o_flag(own_address_hit_flag)
  );

  // Wake is only raised while the device sits in power saving.
  always_comb begin
    wake_next = 1'b0;
    if (i_frame_valid & i_power_saving) begin
      if (pattern_wake_on_reg & i_pattern_hit) begin
        wake_next = 1'b1;
      end
      if (global_unicast_wake_on_reg & pattern_wake_on_reg & global_unicast_frame) begin
        wake_next = 1'b1;
      end
      if (own_address_wake_on_reg & own_addr_match) begin
        wake_next = 1'b1;
      end
    end
  end

  // The wake event is registered so the power controller sees a clean single pulse.
  // It trails the qualifying frame by one cycle.
  // Back to back qualifying frames give back to back pulses.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_event_reg <= 1'b0;
    end else begin
      wake_event_reg <= wake_next;
    end
  end

  // Matcher lookup port; an index past the last dword reads as zero.
  // The lookup is independent of the bus pointers, so matching never moves them.
  // Its data trails the index by one cycle, which the matcher must allow for.
  // A lookup and a window write in one cycle see the old dword.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_data_reg <= RESET_FILTER_WORD;
    end else if (i_match_index > LAST_INDEX) begin
      match_data_reg <= RESET_FILTER_WORD;
    end else begin
      match_data_reg <= filter_store[i_match_index];
    end
  end

  assign o_match_data = match_data_reg;
  assign o_wake_event = wake_event_reg;
  assign o_global_unicast_wake_on = global_unicast_wake_on_reg;
  assign o_pattern_wake_on = pattern_wake_on_reg;
  assign o_own_address_wake_on = own_address_wake_on_reg;
  assign o_own_address_hit_flag = own_address_hit_flag;
  assign o_filter_rd_ptr = rd_ptr;
  assign o_filter_wr_ptr = wr_ptr;

endmodule : wakeup_filter_access

/* design/wrap_pointer.sv */
`timescale 1ns/10ps
module wrap_pointer #(
  parameter int unsigned DEPTH = wake_pkg::FILTER_WORDS,
  parameter int unsigned PTR_W = wake_pkg::PTR_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_clear,
  output logic [PTR_W-1:0] o_ptr
);
  import wake_pkg::*;

  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] FIRST = PTR_W'(0);

  logic [PTR_W-1:0] ptr_reg;

  // Clear outranks a step so a software resync always lands on the first entry.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg <= FIRST;
    end else if (i_clear) begin
      ptr_reg <= FIRST;
    end else if (i_step) begin
      ptr_reg <= (ptr_reg == LAST) ? FIRST : ptr_reg + 1'b1;
    end
  end

  assign o_ptr = ptr_reg;

endmodule : wrap_pointer
